// *** common/tcr_regs.svh ***
// Register indices, field positions, reset values and timing figures of the terminal registers.
`ifndef TCR_REGS_SVH
`define TCR_REGS_SVH

`define TCR_IDX_CFG5     10'h009
`define TCR_IDX_STACK    10'h00A
`define TCR_IDX_FRAME    10'h00B
`define TCR_IDX_MSG      10'h00C
`define TCR_IDX_MODE     10'h00D

`define TCR_B_CLKSRC     15
`define TCR_B_SNGL       14
`define TCR_B_TXA        13
`define TCR_B_TXB        12
`define TCR_B_SEDGE      11
`define TCR_B_TMO_HI     10
`define TCR_B_TMO_LO     9
`define TCR_B_GAP        8
`define TCR_B_BCST       7
`define TCR_B_LATST      6
`define TCR_B_ADDR_HI    5

`define TCR_CFG5_WMASK   16'h0FBF
`define TCR_RST16        16'h0000
`define TCR_BCAST_ADDR   5'h1F

`define TCR_CLK_NS       10
`define TCR_GAP_MIN_NS   2000
`define TCR_TMO0_NS      18500
`define TCR_TMO1_NS      22500
`define TCR_TMO2_NS      50500
`define TCR_TMO3_NS      130000
`define TCR_MSG_LSB_NS   1000
`define TCR_FRAME_LSB_NS 100000

`endif

// *** common/tcr_pkg.sv ***
// Types shared by the terminal register block and its countdown timer.
package tcr_pkg;

    typedef enum logic [3:0] {
        TCR_MODE_BC  = 4'h1,
        TCR_MODE_EBC = 4'h2,
        TCR_MODE_RT  = 4'h4,
        TCR_MODE_MON = 4'h8
    } tcr_mode_t;

    typedef struct packed {
        logic       clock_source_select_bit;
        logic       single_ended_pin;
        logic       bus_a_tx_block_pin;
        logic       bus_b_tx_block_pin;
        logic       address_latch_pin;
        logic       address_latch_enable;
        logic [5:0] address_pins;
    } tcr_pins_t;

    typedef struct packed {
        logic        command_valid;
        logic [15:0] command_word;
        logic        rx_word_valid;
        logic [15:0] rx_word;
        logic        bus_active;
        logic        message_start;
        logic        frame_start;
        logic        msg_time_load;
        logic [15:0] msg_time_value;
        logic        stack_ptr_inc;
    } tcr_evt_t;

endpackage

// *** verilog/tcr_timer.sv ***
// Loadable sixteen-bit countdown timer with a prescaler of one LSB period.
`timescale 1ns/1ps
`default_nettype none

module tcr_timer
    import tcr_pkg::*;
#(
    parameter int LSB_CYCLES = 100
) (
    // Clock, reset and clock enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // Control
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [15:0] load_value,
    // Remaining time
    output logic      [15:0] count
);

    logic [15:0] pre;
    wire         active   = run && (count != 16'h0000);
    wire         lsb_done = (pre == 16'(LSB_CYCLES - 1));

    // The prescaler restarts on load so the first LSB is a full period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre   <= 16'h0000;
            count <= 16'h0000;
        end else if (ce) begin
            if (load) begin
                pre   <= 16'h0000;
                count <= load_value;
            end else if (active) begin
                pre   <= lsb_done ? 16'h0000 : 16'(pre + 16'h0001);
                count <= lsb_done ? 16'(count - 16'h0001) : count;
            end
        end
    end

    a_timer_step: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (!load && active && lsb_done) |=> (count == 16'($past(count) - 16'h0001)))
        else $error("timer did not step down at end of LSB period");

    a_timer_hold: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (!load && (!active || !lsb_done)) |=> $stable(count))
        else $error("timer changed between LSB periods");

endmodule

`default_nettype wire

// *** verilog/tcr_top.sv ***
// Terminal configuration, stack pointer, BC timers and mode word registers on APB.
`timescale 1ns/1ps
`default_nettype none
`include "tcr_regs.svh"

module tcr_top
    import tcr_pkg::*;
#(
    parameter int FRAME_LSB_CYCLES = `TCR_FRAME_LSB_NS / `TCR_CLK_NS
) (
    // Clock, reset and clock enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device pins and mode
    input  wire tcr_pins_t   pins,
    input  wire tcr_mode_t   mode,
    // Protocol engine events
    input  wire tcr_evt_t    evt,
    // Configuration towards the engines
    output logic             decode_both_edges,
    output logic      [13:0] rt_timeout_cycles,
    output logic      [5:0]  rt_address_word,
    output logic      [15:0] data_stack_ptr,
    output logic      [15:0] instr_ptr_init,
    // Engine results
    output logic             gap_violation,
    output logic             is_broadcast,
    output logic             cmd_for_us,
    output logic             monitor_start
);

    localparam int GAP_CYC   = (`TCR_GAP_MIN_NS + `TCR_CLK_NS - 1) / `TCR_CLK_NS;
    localparam int MSG_CYC   = `TCR_MSG_LSB_NS / `TCR_CLK_NS;
    localparam int TMO0_CYC  = `TCR_TMO0_NS / `TCR_CLK_NS;
    localparam int TMO1_CYC  = `TCR_TMO1_NS / `TCR_CLK_NS;
    localparam int TMO2_CYC  = `TCR_TMO2_NS / `TCR_CLK_NS;
    localparam int TMO3_CYC  = `TCR_TMO3_NS / `TCR_CLK_NS;
    localparam logic [7:0] GAP_MAX = 8'(GAP_CYC);

    // Byte lanes 0 and 1 carry the sixteen register bits.
    function automatic logic [15:0] apply_strobe(input logic [15:0] old,
                                                 input logic [31:0] wd,
                                                 input logic [3:0]  strb);
        logic [15:0] res;
        res       = old;
        res[7:0]  = strb[0] ? wd[7:0]  : old[7:0];
        res[15:8] = strb[1] ? wd[15:8] : old[15:8];
        return res;
    endfunction

    function automatic logic [13:0] timeout_cycles(input logic [1:0] sel);
        logic [13:0] c;
        c = 14'(TMO0_CYC);
        case (sel)
            2'h0:    c = 14'(TMO0_CYC);
            2'h1:    c = 14'(TMO1_CYC);
            2'h2:    c = 14'(TMO2_CYC);
            2'h3:    c = 14'(TMO3_CYC);
            default: c = 14'(TMO0_CYC);
        endcase
        return c;
    endfunction

    logic [15:0] cfg5_rw;
    logic [15:0] mode_word;
    logic [7:0]  gap_cnt;
    logic [15:0] frame_left;
    logic [15:0] msg_left;

    // APB decode. One wait state: pready rises in the second access cycle.
    wire [9:0]  reg_idx    = paddr[11:2];
    wire        sel_cfg5   = (reg_idx == `TCR_IDX_CFG5);
    wire        sel_stack  = (reg_idx == `TCR_IDX_STACK);
    wire        sel_frame  = (reg_idx == `TCR_IDX_FRAME);
    wire        sel_msg    = (reg_idx == `TCR_IDX_MSG);
    wire        sel_mode   = (reg_idx == `TCR_IDX_MODE);
    wire        mapped     = sel_cfg5 | sel_stack | sel_frame | sel_msg | sel_mode;
    wire        access     = psel && penable;
    wire        capture    = access && !pready;
    wire        fire       = access && pready;
    wire        wr_ok      = fire && pwrite && mapped && !pslverr;
    wire        wr_cfg5    = wr_ok && sel_cfg5;
    wire        wr_stack   = wr_ok && sel_stack;
    wire        wr_mode    = wr_ok && sel_mode;

    wire        bc_mode    = (mode == TCR_MODE_BC) || (mode == TCR_MODE_EBC);
    wire        rt_mode    = (mode == TCR_MODE_RT);
    wire        mon_mode   = (mode == TCR_MODE_MON);

    // Status bits are taken from the pins at read time, never stored.
    wire [15:0] cfg5_view  = {pins.clock_source_select_bit,
                              pins.single_ended_pin,
                              pins.bus_a_tx_block_pin,
                              pins.bus_b_tx_block_pin,
                              cfg5_rw[11:7],
                              pins.address_latch_pin,
                              cfg5_rw[5:0]};

    wire [15:0] rd_word    = sel_cfg5  ? cfg5_view      :
                             sel_stack ? data_stack_ptr :
                             sel_frame ? frame_left     :
                             sel_msg   ? msg_left       :
                             sel_mode  ? mode_word      :
                                         `TCR_RST16;

    wire [15:0] cfg5_wr    = apply_strobe(cfg5_rw, pwdata, pstrb) & `TCR_CFG5_WMASK;
    wire        latch_now  = pins.address_latch_enable && pins.address_latch_pin;
    wire [15:0] next_cfg5  = {cfg5_wr[15:6], latch_now ? pins.address_pins : cfg5_wr[5:0]};

    wire [4:0]  cmd_addr   = evt.command_word[15:11];
    wire        bcast_hit  = (cmd_addr == `TCR_BCAST_ADDR) && !cfg5_rw[`TCR_B_BCST];
    wire        own_hit    = (cmd_addr == cfg5_rw[`TCR_B_ADDR_HI:1]);
    wire        gap_short  = (gap_cnt < GAP_MAX);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= capture;
            pslverr <= capture && !mapped;
            if (capture) begin
                prdata <= {16'h0000, mapped ? rd_word : `TCR_RST16};
            end
        end
    end

    // Configuration register. A pin latch wins over a host write of the address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg5_rw <= `TCR_RST16;
        end else if (ce) begin
            if (wr_cfg5) begin
                cfg5_rw <= next_cfg5;
            end else if (latch_now) begin
                cfg5_rw[`TCR_B_ADDR_HI:0] <= pins.address_pins;
            end
        end
    end

    // Stack pointer. An engine increment in the write cycle is kept on top of the write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_stack_ptr <= `TCR_RST16;
        end else if (ce) begin
            if (wr_stack) begin
                data_stack_ptr <= 16'(apply_strobe(data_stack_ptr, pwdata, pstrb)
                                      + {15'h0000, evt.stack_ptr_inc});
            end else if (evt.stack_ptr_inc) begin
                data_stack_ptr <= 16'(data_stack_ptr + 16'h0001);
            end
        end
    end

    // Mode word. In RT mode a processed command overrides a simultaneous host write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_word <= `TCR_RST16;
        end else if (ce) begin
            if (rt_mode && evt.command_valid) begin
                mode_word <= evt.command_word;
            end else if (wr_mode) begin
                mode_word <= apply_strobe(mode_word, pwdata, pstrb);
            end
        end
    end

    // Idle time since the bus went quiet, saturating at the minimum gap.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt <= 8'hFF;
        end else if (ce) begin
            if (evt.bus_active) begin
                gap_cnt <= 8'h00;
            end else if (gap_short) begin
                gap_cnt <= 8'(gap_cnt + 8'h01);
            end
        end
    end

    // Registered outputs towards the engines.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decode_both_edges <= 1'b1;
            rt_timeout_cycles <= 14'(TMO0_CYC);
            rt_address_word   <= 6'h00;
            instr_ptr_init    <= `TCR_RST16;
            gap_violation     <= 1'b0;
            is_broadcast      <= 1'b0;
            cmd_for_us        <= 1'b0;
            monitor_start     <= 1'b0;
        end else if (ce) begin
            decode_both_edges <= !cfg5_rw[`TCR_B_SEDGE];
            rt_timeout_cycles <= timeout_cycles(cfg5_rw[`TCR_B_TMO_HI:`TCR_B_TMO_LO]);
            rt_address_word   <= cfg5_rw[`TCR_B_ADDR_HI:0];
            instr_ptr_init    <= mode_word;
            gap_violation     <= evt.message_start && cfg5_rw[`TCR_B_GAP] && gap_short;
            is_broadcast      <= evt.command_valid && bcast_hit;
            cmd_for_us        <= evt.command_valid && (bcast_hit || own_hit);
            monitor_start     <= mon_mode && evt.rx_word_valid
                                 && (evt.rx_word == mode_word);
        end
    end

    // Frame timer loads the programmed frame time at each frame start in BC or EBC mode.
    tcr_timer #(
        .LSB_CYCLES (FRAME_LSB_CYCLES)
    ) u_frame_timer (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .run        (bc_mode),
        .load       (bc_mode && evt.frame_start),
        .load_value (mode_word),
        .count      (frame_left)
    );

    tcr_timer #(
        .LSB_CYCLES (MSG_CYC)
    ) u_msg_timer (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .run        (bc_mode),
        .load       (bc_mode && evt.msg_time_load),
        .load_value (evt.msg_time_value),
        .count      (msg_left)
    );

    wire rd_cfg5 = capture && !pwrite && sel_cfg5;

    a_clksrc_mirror: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        rd_cfg5 |=> (prdata[`TCR_B_CLKSRC] == $past(pins.clock_source_select_bit)))
        else $error("bit 15 does not return clock select");

    a_single_end_mirror: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        rd_cfg5 |=> (prdata[`TCR_B_SNGL] == $past(pins.single_ended_pin)))
        else $error("bit 14 does not mirror single-ended pin");

    a_inhibit_mirror: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        rd_cfg5 |=> (prdata[`TCR_B_TXA] == $past(pins.bus_a_tx_block_pin))
                    && (prdata[`TCR_B_TXB] == $past(pins.bus_b_tx_block_pin)))
        else $error("inhibit bits do not mirror pins");

    a_latch_status: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        rd_cfg5 |=> (prdata[`TCR_B_LATST] == $past(pins.address_latch_pin)))
        else $error("bit 6 does not mirror latch pin");

    a_decode_edges: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        ##1 ce |-> (decode_both_edges == !$past(cfg5_rw[`TCR_B_SEDGE])))
        else $error("decode edge select wrong");

    a_timeout_sel: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (cfg5_rw[10:9] == 2'h3) ##1 ce |-> (rt_timeout_cycles == 14'h32C8))
        else $error("longest timeout not 130 us");

    a_gap_check: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (evt.message_start && cfg5_rw[`TCR_B_GAP]
         && ($past(evt.bus_active) || $past(evt.bus_active, 2)))
        |=> gap_violation)
        else $error("short gap not flagged");

    a_broadcast_off: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (evt.command_valid && cfg5_rw[`TCR_B_BCST]) |=> !is_broadcast)
        else $error("broadcast seen while disabled");

    a_addr_latch: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (!latch_now && !wr_cfg5) |=> $stable(cfg5_rw[5:0]))
        else $error("address changed without latch or write");

    a_last_command: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (rt_mode && evt.command_valid) |=> (mode_word == $past(evt.command_word)))
        else $error("last command not stored");

    a_monitor_trig: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        monitor_start |-> $past(mon_mode && evt.rx_word_valid && evt.rx_word == mode_word))
        else $error("monitor start without trigger match");

    a_reset_zero: assert property (
        @(posedge pclk)
        !presetn |-> (cfg5_rw == 16'h0000 && mode_word == 16'h0000
                      && data_stack_ptr == 16'h0000))
        else $error("registers not zero in reset");

    a_broadcast_on: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (evt.command_valid && evt.command_word[15:11] == `TCR_BCAST_ADDR
         && !cfg5_rw[`TCR_B_BCST]) |=> (is_broadcast && cmd_for_us))
        else $error("broadcast address not recognised");

    a_gap_quiet: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (evt.message_start && !cfg5_rw[`TCR_B_GAP]) |=> !gap_violation)
        else $error("gap flagged while check disabled");

    a_stack_write: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (wr_stack && pstrb[1:0] == 2'h3 && !evt.stack_ptr_inc)
        |=> (data_stack_ptr == $past(pwdata[15:0])))
        else $error("stack pointer write lost");

    // Status bits are never stored, so a host write cannot leave a stale copy behind.
    a_status_unstored: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        (cfg5_rw[15:12] == 4'h0) && !cfg5_rw[`TCR_B_LATST])
        else $error("read-only status bits held in register");

endmodule

`default_nettype wire

// *** tb/tcr_apb_host.sv ***
// APB host model that issues single transfers to the register block.
`timescale 1ns/1ps
`default_nettype none

module tcr_apb_host (
    // Clock
    input  wire logic        pclk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end

    // The request is held until pready is seen high; the wait is bounded.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        ok = 1'b0;
        rd = '0;
        err = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                rd = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data must not look like a held value.
        pwdata <= ~d;
    endtask
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking testbench of the terminal register block.
`timescale 1ns/1ps
`default_nettype none
`include "tcr_regs.svh"

module tb_top
    import tcr_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b1;
    logic        ce = 1'b1;
    wire         psel, penable, pwrite;
    wire [11:0]  paddr;
    wire [31:0]  pwdata;
    wire [3:0]   pstrb;
    logic [31:0] prdata;
    logic        pready, pslverr, dbe, gapv, bcst, forus, mstart;
    logic [13:0] tmo;
    logic [5:0]  rta;
    logic [15:0] dsp, ipi, sh, v;
    tcr_pins_t   pins;
    tcr_mode_t   mode;
    tcr_evt_t    evt;
    logic [31:0] rd;
    logic        er, ok;
    int          err_total = 0;
    int          num_checks = 0;
    int          i;

    always #5 pclk = ~pclk;

    tcr_top #(.FRAME_LSB_CYCLES(8)) tcr_top_i (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .mode(mode), .evt(evt), .decode_both_edges(dbe), .rt_timeout_cycles(tmo),
        .rt_address_word(rta), .data_stack_ptr(dsp), .instr_ptr_init(ipi),
        .gap_violation(gapv), .is_broadcast(bcst), .cmd_for_us(forus), .monitor_start(mstart));

    tcr_apb_host tcr_apb_host_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task final_report;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task rw(input logic w, input logic [9:0] idx, input logic [31:0] d);
        tcr_apb_host_i.xfer(w, {idx, 2'b00}, d, rd, er, ok);
        if (!ok) begin
            err_total++;
            final_report();
        end
    endtask

    // Pulses one engine event for a single cycle and returns just after its result edge.
    task ev(input int k, input logic [15:0] w);
        @(posedge pclk);
        case (k)
            0: begin
                evt.command_valid <= 1'b1;
                evt.command_word <= w;
            end
            1: begin
                evt.rx_word_valid <= 1'b1;
                evt.rx_word <= w;
            end
            2: evt.message_start <= 1'b1;
            3: evt.frame_start <= 1'b1;
            default: begin
                evt.msg_time_load <= 1'b1;
                evt.msg_time_value <= w;
            end
        endcase
        @(posedge pclk);
        {evt.command_valid, evt.rx_word_valid, evt.message_start} <= '0;
        {evt.frame_start, evt.msg_time_load} <= '0;
        #1;
    endtask

    function automatic logic [31:0] f_cfg5(input logic [15:0] s);
        return {16'h0000, pins.clock_source_select_bit, pins.single_ended_pin,
                pins.bus_a_tx_block_pin, pins.bus_b_tx_block_pin, s[11:7],
                pins.address_latch_pin, s[5:0]};
    endfunction

    function automatic logic [13:0] f_tmo(input logic [1:0] s);
        return (s == 2'd0) ? 14'h073A :
               (s == 2'd1) ? 14'h08CA :
               (s == 2'd2) ? 14'h13BA : 14'h32C8;
    endfunction

    initial begin
        // A real falling edge at time zero lets the asynchronous reset act at once.
        presetn <= 1'b0;
        pins = '0;
        evt = '0;
        mode = TCR_MODE_RT;
        sh = '0;
        i = $urandom(32'h37fae016);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 9; i < 14; i++) begin
            rw(1'b0, 10'(i), 32'h0);
            chk(rd, 32'h0);
        end
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            pins <= tcr_pins_t'(12'($urandom) & 12'hFBF);
            rw(1'b0, `TCR_IDX_CFG5, 32'h0);
            chk(rd, f_cfg5(sh));
        end
        $display("test mirrors done");
        for (i = 0; i < 8; i++) begin
            v = 16'($urandom);
            v[10:9] = 2'(i);
            rw(1'b1, `TCR_IDX_CFG5, {16'($urandom), v});
            sh = v & `TCR_CFG5_WMASK;
            rw(1'b0, `TCR_IDX_CFG5, 32'h0);
            chk(rd, f_cfg5(sh));
            chk(32'(dbe), 32'(!sh[11]));
            chk(32'(tmo), 32'(f_tmo(sh[10:9])));
            chk(32'(rta), 32'(sh[5:0]));
        end
        @(posedge pclk);
        {pins.address_latch_enable, pins.address_latch_pin, pins.address_pins} <= 8'hEB;
        sh[5:0] = 6'h2B;
        rw(1'b0, `TCR_IDX_CFG5, 32'h0);
        chk(rd, f_cfg5(sh));
        pins.address_latch_pin <= 1'b0;
        pins.address_pins <= 6'h14;
        rw(1'b0, `TCR_IDX_CFG5, 32'h0);
        chk(rd, f_cfg5(sh));
        pins.address_latch_enable <= 1'b0;
        $display("test config done");
        v = 16'($urandom);
        rw(1'b1, `TCR_IDX_STACK, 32'(v));
        rw(1'b0, `TCR_IDX_STACK, 32'h0);
        chk(rd, 32'(v));
        chk(32'(dsp), 32'(v));
        // Outside bus controller mode the timers stay at zero and refuse writes.
        rw(1'b1, `TCR_IDX_FRAME, 32'hFFFF);
        rw(1'b0, `TCR_IDX_FRAME, 32'h0);
        chk(rd, 32'h0);
        rw(1'b1, `TCR_IDX_MSG, 32'hFFFF);
        rw(1'b0, `TCR_IDX_MSG, 32'h0);
        chk(rd, 32'h0);
        rw(1'b1, 10'h3FF, 32'h1234);
        chk(32'(er), 32'h1);
        $display("test access done");
        v = 16'($urandom % 31);
        for (i = 0; i < 2; i++) begin
            rw(1'b1, `TCR_IDX_CFG5, 32'((i << 7) | (v[4:0] << 1)));
            ev(0, {5'h1F, 11'($urandom)});
            chk(32'(bcst), 32'(i == 0));
        end
        ev(0, {v[4:0], 11'h123});
        chk(32'({forus, bcst}), 32'h2);
        rw(1'b0, `TCR_IDX_MODE, 32'h0);
        chk(rd, 32'({v[4:0], 11'h123}));
        mode <= TCR_MODE_MON;
        v = 16'($urandom);
        rw(1'b1, `TCR_IDX_MODE, 32'(v));
        ev(1, v ^ 16'h0001);
        chk(32'(mstart), 32'h0);
        ev(1, v);
        chk(32'(mstart), 32'h1);
        $display("test engine done");
        for (i = 0; i < 2; i++) begin
            rw(1'b1, `TCR_IDX_CFG5, 32'(i << 8));
            @(posedge pclk);
            evt.bus_active <= 1'b1;
            @(posedge pclk);
            evt.bus_active <= 1'b0;
            ev(2, 16'h0);
            chk(32'(gapv), 32'(i));
        end
        repeat (210) @(posedge pclk);
        ev(2, 16'h0);
        chk(32'(gapv), 32'h0);
        $display("test gap done");
        @(posedge pclk);
        mode <= TCR_MODE_BC;
        ev(4, 16'h0002);
        rw(1'b0, `TCR_IDX_MSG, 32'h0);
        chk(rd, 32'h2);
        // With the clock enable low the timer must not lose an LSB period.
        ce <= 1'b0;
        repeat (150) @(posedge pclk);
        ce <= 1'b1;
        rw(1'b0, `TCR_IDX_MSG, 32'h0);
        chk(rd, 32'h2);
        repeat (300) @(posedge pclk);
        rw(1'b0, `TCR_IDX_MSG, 32'h0);
        chk(rd, 32'h0);
        rw(1'b1, `TCR_IDX_MODE, 32'h3);
        ev(3, 16'h0);
        rw(1'b0, `TCR_IDX_FRAME, 32'h0);
        chk(rd, 32'h3);
        repeat (60) @(posedge pclk);
        rw(1'b0, `TCR_IDX_FRAME, 32'h0);
        chk(rd, 32'h0);
        mode <= TCR_MODE_EBC;
        v = 16'($urandom);
        rw(1'b1, `TCR_IDX_MODE, 32'(v));
        repeat (2) @(posedge pclk);
        chk(32'(ipi), 32'(v));
        $display("test timers done");
        final_report();
    end
endmodule

`default_nettype wire
